// ===== dv/rtcac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// three-wire host: select, link clock and data towards the device
module rtcac_host_model (
  output logic      o_cs,
  output logic      o_sclk,
  output logic      o_io,
  input  wire logic i_io
);
  localparam realtime HALF = 7.5;

  // link idles with select low and the clock standing still
  initial begin
    o_cs   = 1'b0;
    o_sclk = 1'b0;
    o_io   = 1'b0;
  end

  // eight bits lsb first, each set up before its rise
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_io = b[i];
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask : put_byte

  // sample device bits at each rise; released line keeps toggling
  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_io = ~o_io;
      #HALF b[i] = i_io;
      o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask : get_byte

  // one frame: command byte, then one data byte
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    rd = 8'h00;
    o_cs = 1'b1;
    #HALF put_byte({wr, a});
    if (wr) begin
      put_byte(wd);
    end else begin
      get_byte(rd);
    end
    #HALF o_cs = 1'b0;
    #(8 * HALF);
  endtask : xfer
endmodule : rtcac_host_model
`default_nettype wire

// ===== dv/tb_rtc_alarm_control_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_control_status;
  import rtcac_pkg::*;
  logic        clk, rst, sclk, cs, host_io, io_line, dev_io, dev_oe_n;
  logic        osc, on_batt, batt_low, conv_pend, conv_vld, osc_run, irq;
  logic [7:0]  conv_res;
  logic [1:0]  in_sel, wd_delay;
  int          n_fail       = 0;
  int          total_checks = 0;
  // address, written value, expected read-back
  logic [23:0] tbl [0:11] = '{
    24'h02_72_72,
    24'h02_23_23,
    24'h02_FF_7F,
    24'h04_FF_3F,
    24'h0C_FF_C0,
    24'h0D_FC_00,
    24'h0E_00_5A,
    24'h0F_55_00,
    24'h7F_AA_00,
    24'h07_85_85,
    24'h0A_81_81,
    24'h0B_BF_B1
  };
  // time and alarm settings: weekly rollover, then seconds-only match
  logic [15:0] tset [0:12] = '{
    16'h00_59, 16'h01_59, 16'h02_23, 16'h03_07,
    16'h07_00, 16'h08_00, 16'h09_00, 16'h0A_01,
    16'h00_03, 16'h07_05, 16'h08_80, 16'h09_80, 16'h0A_80
  };

  rtcac_top #(.SEC_DIV(4)) rtcac_top_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_cs(cs),
    .i_io(io_line), .o_io(dev_io), .o_io_oe_n(dev_oe_n),
    .i_osc_32k(osc), .i_on_battery(on_batt), .i_battery_low(batt_low),
    .i_conv_pending(conv_pend), .i_conv_valid(conv_vld),
    .i_conv_result(conv_res), .o_input_select(in_sel),
    .o_watchdog_delay(wd_delay), .o_osc_run(osc_run), .o_irq(irq)
  );
  rtcac_host_model rtcac_host_model_inst (
    .o_cs(cs), .o_sclk(sclk), .o_io(host_io), .i_io(io_line)
  );
  // wire level of the shared data pin
  assign io_line = dev_oe_n ? host_io : dev_io;

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // slow oscillator, 1 us period, so one second is 4 us
  initial begin
    osc = 1'b0;
    forever begin
      repeat (50) @(negedge clk);
      osc = ~osc;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    rtcac_host_model_inst.xfer(1'b1, a, d, unused);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    rtcac_host_model_inst.xfer(1'b0, a, 8'h00, got);
    chk(got, exp);
  endtask : rd

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // bounded wait for the interrupt line; running out counts as a miss
  task automatic wait_irq();
    for (int i = 0; i < 1500; i++) begin
      if (irq === 1'b1) break;
      @(negedge clk);
    end
    chk({7'h00, irq}, 8'h01);
  endtask : wait_irq

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // hang guard, several times the expected run length
  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    rst       = 1'b1;
    on_batt   = 1'b0;
    batt_low  = 1'b1;
    conv_pend = 1'b1;
    conv_vld  = 1'b0;
    conv_res  = 8'h00;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wait_clk(10);
    rd(A_CTRL, 8'h80);
    rd(A_WDOG, 8'h03);
    chk({wd_delay, in_sel, osc_run, irq, 2'b00}, 8'hC8);
    chk({7'h00, dev_oe_n}, 8'h01);
    end_test("reset");
    // frames end on a falling clock edge here; step off it before driving
    wait_clk(1);
    conv_res = 8'h5A;
    conv_vld = 1'b1;
    @(negedge clk);
    conv_vld = 1'b0;
    foreach (tbl[i]) begin
      wr(tbl[i][22:16], tbl[i][15:8]);
      rd(tbl[i][22:16], tbl[i][7:0]);
    end
    chk({6'h00, wd_delay}, 8'h00);
    end_test("registers");
    for (int k = 0; k < 4; k++) begin
      wr(A_CTRL, 8'h80 | 8'(k << 4));
      wait_clk(10);
      chk({6'h00, in_sel}, 8'(k));
    end
    on_batt = 1'b1;
    wait_clk(10);
    chk({7'h00, osc_run}, 8'h00);
    on_batt = 1'b0;
    wait_clk(10);
    chk({7'h00, osc_run}, 8'h01);
    end_test("select");
    wr(A_CTRL, 8'hC0);
    wr(7'h01, 8'h33);
    rd(7'h01, 8'h00);
    wr(A_ALM0, 8'h33);
    rd(A_ALM0, 8'h85);
    wr(A_CTRL, 8'h91);
    rd(A_CTRL, 8'h80);
    end_test("protect");
    for (int i = 0; i < 8; i++) wr(tset[i][14:8], tset[i][7:0]);
    wait_clk(600);
    rd(7'h00, 8'h59);
    wr(A_CTRL, 8'h01);
    wait_irq();
    for (int a = 0; a < 4; a++) rd(7'(a), (a == 3) ? 8'h01 : 8'h00);
    rd(A_STAT, 8'hC1);
    chk({7'h00, irq}, 8'h01);
    rd(A_ALM0, 8'h00);
    wait_clk(10);
    chk({7'h00, irq}, 8'h00);
    rd(A_STAT, 8'hC0);
    end_test("weekly");
    wr(A_CTRL, 8'h81);
    for (int i = 8; i < 13; i++) wr(tset[i][14:8], tset[i][7:0]);
    wr(A_CTRL, 8'h01);
    wait_irq();
    rd(7'h00, 8'h05);
    wr(A_CTRL, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(A_STAT, 8'hC1);
    wr(A_CTRL, 8'h01);
    chk({7'h00, irq}, 8'h01);
    end_test("seconds");
    // 11:59:59 pm in 12-hour mode rolls to 12 am of the next day
    wr(A_CTRL, 8'h80);
    wr(7'h02, 8'h71);
    wr(7'h01, 8'h59);
    wr(7'h00, 8'h59);
    wr(A_CTRL, 8'h00);
    wait_clk(450);
    rd(7'h02, 8'h52);
    rd(7'h03, 8'h02);
    end_test("twelve hour");
    finish_test();
  end
endmodule : tb_rtc_alarm_control_status
`default_nettype wire

// ===== src/rtcac_pkg.sv
// What this block does
// - fixed-zero bits always read back zero
// - addresses 0Fh-7Fh read zero, ignore writes
// - time, calendar and alarm held in BCD
// - hours bit 6 high selects 12-hour mode
// - 12-hour mode: hours bit 5 is PM
// - 24-hour mode: hours bit 5 is tens digit
// - alarms at 07h-0Ah, bit 7 masks field
// - no masks weekly match, day mask daily
// - more masks: hourly, each minute, each second
// - oscillator-disable stops oscillator on battery only
// - on main supply, time advances only when enabled
// - write protect blocks all register writes except the protect bit
// - control bits 5:4 pick converter input
// - alarm enable gates flag onto interrupt
// - time match sets flag, enable raises interrupt
// - any alarm register access clears flag
// - status bit 7 reports conversion update pending
// - status bit 6 reports backup battery low
// - power-up: oscillator-disable set, watchdog 11, day/date/month 01, rest clear
// - interrupt holds while flag and enable set
package rtcac_pkg;
  localparam int         BYTE_W    = 8;
  localparam int         ADDR_W    = 7;
  localparam int         OSC_HZ    = 32768;
  localparam logic [6:0] A_ALM0    = 7'h07;
  localparam logic [6:0] A_ALM3    = 7'h0A;
  localparam logic [6:0] A_CTRL    = 7'h0B;
  localparam logic [6:0] A_STAT    = 7'h0C;
  localparam logic [6:0] A_WDOG    = 7'h0D;
  localparam logic [6:0] A_CONV    = 7'h0E;
  localparam int         NREG      = 15;
  localparam int         CTRL_OSC  = 7;
  localparam int         CTRL_WP   = 6;
  localparam int         CTRL_AIE  = 0;
  localparam int         HR_12H    = 6;
  localparam int         HR_PM     = 5;
  localparam int         ALM_MASK  = 7;
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [7:0] CTRL_WM   = 8'hF1;
  localparam logic [7:0] WDOG_RST  = 8'h03;
  localparam logic [7:0] WDOG_WM   = 8'h03;
  localparam logic [7:0] SEC_LAST  = 8'h59;
  localparam logic [7:0] H24_LAST  = 8'h23;
  localparam logic [7:0] H12_LAST  = 8'h12;
  localparam logic [7:0] H12_PRE   = 8'h11;
  localparam logic [7:0] DAY_LAST  = 8'h07;
  localparam logic [7:0] MON_LAST  = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] TIME_WM [0:6] =
    '{8'h7F, 8'h7F, 8'h7F, 8'h07, 8'h3F, 8'h1F, 8'hFF};
  localparam logic [7:0] TIME_RST [0:6] =
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
endpackage : rtcac_pkg

// ===== src/rtcac_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtcac_top #(
  parameter int SEC_DIV = rtcac_pkg::OSC_HZ
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_sclk,
  input  wire logic                        i_cs,
  input  wire logic                        i_io,
  output logic                             o_io,
  output logic                             o_io_oe_n,
  input  wire logic                        i_osc_32k,
  input  wire logic                        i_on_battery,
  input  wire logic                        i_battery_low,
  input  wire logic                        i_conv_pending,
  input  wire logic                        i_conv_valid,
  input  wire logic [rtcac_pkg::BYTE_W-1:0] i_conv_result,
  output logic [1:0]                       o_input_select,
  output logic [1:0]                       o_watchdog_delay,
  output logic                             o_osc_run,
  output logic                             o_irq
);
  import rtcac_pkg::*;

  localparam int         DIV_W    = $clog2(SEC_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_DIV - 1);

  if (SEC_DIV < 2) begin : g_chk
    $error("SEC_DIV must be at least 2");
  end

  // bcd helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                               : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] roll(input logic [7:0] v,
                                      input logic [7:0] last,
                                      input logic [7:0] first);
    roll = (v == last) ? first : bcd_inc(v);
  endfunction : roll

  function automatic logic [7:0] days_in(input logic [7:0] mon,
                                         input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      days_in = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default:                    days_in = 8'h31;
    endcase
  endfunction : days_in

  function automatic logic [6:0] next_addr(input logic [6:0] a);
    next_addr = (a == A_CONV) ? 7'h00 : a + 7'h01;
  endfunction : next_addr

  // ---------------- link side, serial clock domain
  logic       frame_rst;
  logic [2:0] bit_q;
  logic       cmd_q;
  logic       rw_q;
  logic [6:0] addr_q;
  logic [7:0] sh_q;
  logic [7:0] sh_in;
  logic       ev_tgl_q;
  logic       ev_wr_q;
  logic [6:0] ev_addr_q;
  logic [7:0] ev_data_q;
  logic       req_s1_q;
  logic       req_s2_q;
  logic       ack_q;
  logic [7:0] bank_q [0:NREG-1];
  logic [7:0] rd_byte;
  logic [7:0] rd_q;
  logic       oe_n_q;

  assign frame_rst = i_sys_rst | ~i_cs;
  assign sh_in     = {i_io, sh_q[7:1]};

  // lsb-first shifter, command capture, address step
  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_q  <= 3'h0;
      cmd_q  <= 1'b0;
      rw_q   <= 1'b0;
      addr_q <= 7'h00;
      sh_q   <= 8'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= sh_in;
      if (bit_q == 3'h7) begin
        if (!cmd_q) begin
          cmd_q  <= 1'b1;
          addr_q <= sh_in[6:0];
          rw_q   <= sh_in[7];
        end else begin
          addr_q <= next_addr(addr_q);
        end
      end
    end
  end

  // one event per finished data byte, fields held until next
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_tgl_q  <= 1'b0;
      ev_wr_q   <= 1'b0;
      ev_addr_q <= 7'h00;
      ev_data_q <= 8'h00;
    end else if (bit_q == 3'h7 && cmd_q) begin
      ev_tgl_q  <= ~ev_tgl_q;
      ev_wr_q   <= rw_q;
      ev_addr_q <= addr_q;
      ev_data_q <= sh_in;
    end
  end

  // register image handshake, link end
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q    <= 1'b0;
      for (int i = 0; i < NREG; i++) bank_q[i] <= 8'h00;
    end else begin
      req_s1_q <= snap_req_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != ack_q) begin
        ack_q  <= req_s2_q;
        bank_q <= snap_q;
      end
    end
  end

  assign rd_byte = (addr_q <= A_CONV) ? bank_q[addr_q[3:0]] : 8'h00;

  // read data out on falling edges, released when select drops
  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rd_q   <= 8'h00;
      oe_n_q <= 1'b1;
    end else if (cmd_q && !rw_q) begin
      oe_n_q <= 1'b0;
      rd_q   <= (bit_q == 3'h0) ? rd_byte : {1'b0, rd_q[7:1]};
    end
  end

  assign o_io      = rd_q[0];
  assign o_io_oe_n = oe_n_q;

  // ---------------- system clock domain
  logic [2:0]       pin_s1_q;
  logic [2:0]       pin_s2_q;
  logic             osc_prev_q;
  logic             ev_s1_q;
  logic             ev_s2_q;
  logic             ev_s3_q;
  logic             ev_stb;
  logic             wr_stb;
  logic             wr_ok;
  logic             alm_access;
  logic [DIV_W-1:0] div_q;
  logic             osc_rise;
  logic             sec_tick;
  logic             cmp_stb_q;
  logic             alarm_hit;
  logic             flag_q;
  logic [7:0]       time_q  [0:6];
  logic [7:0]       time_nx [0:6];
  logic [7:0]       alarm_q [0:3];
  logic [7:0]       ctrl_q;
  logic [7:0]       wd_q;
  logic [7:0]       conv_q;
  logic [7:0]       cur     [0:NREG-1];
  logic [7:0]       snap_q  [0:NREG-1];
  logic             snap_req_q;
  logic             ack_s1_q;
  logic             ack_s2_q;

  // pin synchronisers: oscillator, battery supply, battery low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1_q   <= 3'h0;
      pin_s2_q   <= 3'h0;
      osc_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= {i_osc_32k, i_on_battery, i_battery_low};
      pin_s2_q   <= pin_s1_q;
      osc_prev_q <= pin_s2_q[2];
    end
  end

  // byte events from the link, toggle synchroniser
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= ev_tgl_q;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  assign ev_stb     = ev_s2_q ^ ev_s3_q;
  assign wr_stb     = ev_stb & ev_wr_q;
  assign wr_ok      = wr_stb & ~ctrl_q[CTRL_WP];
  assign alm_access = ev_stb & (ev_addr_q >= A_ALM0) &
                      (ev_addr_q <= A_ALM3);
  assign osc_rise   = pin_s2_q[2] & ~osc_prev_q;
  assign sec_tick   = osc_rise & (div_q == DIV_LAST) &
                      ~ctrl_q[CTRL_OSC];

  // one-second divider, kept at zero while timekeeping is stopped
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_q <= '0;
    end else if (ctrl_q[CTRL_OSC]) begin
      div_q <= '0;
    end else if (osc_rise) begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end

  // next time and calendar in bcd
  always_comb begin
    logic       cy;
    logic [7:0] h;
    logic [7:0] t;
    cy = 1'b0;
    h  = 8'h00;
    t  = 8'h00;
    for (int i = 0; i < 7; i++) time_nx[i] = time_q[i];
    time_nx[0] = roll(time_q[0], SEC_LAST, 8'h00);
    if (time_q[0] == SEC_LAST) begin
      time_nx[1] = roll(time_q[1], SEC_LAST, 8'h00);
      cy = (time_q[1] == SEC_LAST);
    end
    if (cy) begin
      if (time_q[2][HR_12H]) begin
        h = {3'h0, time_q[2][4:0]};
        t = roll(h, H12_LAST, BCD_ONE);
        time_nx[2] = {2'b01, time_q[2][HR_PM] ^ (h == H12_PRE),
                      t[4:0]};
        cy = time_q[2][HR_PM] & (h == H12_PRE);
      end else begin
        h = {2'h0, time_q[2][5:0]};
        t = roll(h, H24_LAST, 8'h00);
        time_nx[2] = {2'b00, t[5:0]};
        cy = (h == H24_LAST);
      end
    end
    if (cy) begin
      time_nx[3] = roll(time_q[3], DAY_LAST, BCD_ONE);
      t = days_in(time_q[5], time_q[6]);
      time_nx[4] = roll(time_q[4], t, BCD_ONE);
      cy = (time_q[4] == t);
    end
    if (cy) begin
      time_nx[5] = roll(time_q[5], MON_LAST, BCD_ONE);
      cy = (time_q[5] == MON_LAST);
    end
    if (cy) time_nx[6] = roll(time_q[6], YEAR_LAST, 8'h00);
  end

  // timekeeping registers: advance, then host write wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      time_q <= TIME_RST;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (wr_ok && ev_addr_q == 7'(i)) begin
          time_q[i] <= ev_data_q & TIME_WM[i];
        end else if (sec_tick) begin
          time_q[i] <= time_nx[i];
        end
      end
    end
  end

  // alarm registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) alarm_q[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_ok && ev_addr_q == A_ALM0 + 7'(i)) begin
          alarm_q[i] <= ev_data_q;
        end
      end
    end
  end

  // control and watchdog delay registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST;
      wd_q   <= WDOG_RST;
    end else if (wr_stb) begin
      if (ev_addr_q == A_CTRL) begin
        if (ctrl_q[CTRL_WP]) begin
          ctrl_q[CTRL_WP] <= ev_data_q[CTRL_WP];
        end else begin
          ctrl_q <= ev_data_q & CTRL_WM;
        end
      end
      if (ev_addr_q == A_WDOG && !ctrl_q[CTRL_WP]) begin
        wd_q <= ev_data_q & WDOG_WM;
      end
    end
  end

  // compare one cycle after each seconds advance
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmp_stb_q <= 1'b0;
    end else begin
      cmp_stb_q <= sec_tick;
    end
  end

  always_comb begin
    alarm_hit = cmp_stb_q;
    for (int i = 0; i < 4; i++) begin
      if (!alarm_q[i][ALM_MASK] &&
          alarm_q[i][6:0] != time_q[i][6:0]) begin
        alarm_hit = 1'b0;
      end
    end
  end

  // request flag: a new match wins over a clearing access
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= alarm_hit | (flag_q & ~alm_access);
    end
  end

  // converter result and oscillator run output
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conv_q    <= 8'h00;
      o_osc_run <= 1'b1;
    end else begin
      if (i_conv_valid) conv_q <= i_conv_result;
      o_osc_run <= ~(ctrl_q[CTRL_OSC] & pin_s2_q[1]);
    end
  end

  assign o_irq            = flag_q & ctrl_q[CTRL_AIE];
  assign o_input_select   = ctrl_q[5:4];
  assign o_watchdog_delay = wd_q[1:0];

  // readable image of all registers
  always_comb begin
    for (int i = 0; i < NREG; i++) cur[i] = 8'h00;
    for (int i = 0; i < 7; i++) cur[i] = time_q[i];
    for (int i = 0; i < 4; i++) cur[7 + i] = alarm_q[i];
    cur[A_CTRL[3:0]] = ctrl_q;
    cur[A_STAT[3:0]] = {i_conv_pending, pin_s2_q[0], 5'h00,
                        flag_q};
    cur[A_WDOG[3:0]] = wd_q;
    cur[A_CONV[3:0]] = conv_q;
  end

  // register image handshake, system end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      snap_req_q <= 1'b0;
      for (int i = 0; i < NREG; i++) snap_q[i] <= 8'h00;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (ack_s2_q == snap_req_q) begin
        snap_q     <= cur;
        snap_req_q <= ~snap_req_q;
      end
    end
  end

  // ---------------- checks
  sequence s_prot_wr;
    wr_stb && ctrl_q[CTRL_WP] && ev_addr_q == A_ALM0;
  endsequence
  sequence s_tick_cmp;
    sec_tick ##1 cmp_stb_q;
  endsequence

  property p_irq_gate;
    @(posedge i_clk) disable iff (i_sys_rst)
      !ctrl_q[CTRL_AIE] |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enable");

  property p_hit_irq;
    @(posedge i_clk) disable iff (i_sys_rst)
      alarm_hit && ctrl_q[CTRL_AIE] |=> o_irq && flag_q;
  endproperty
  a_hit_irq: assert property (p_hit_irq)
    else $error("match did not raise interrupt");

  property p_alm_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      alm_access && !alarm_hit |=> !flag_q && !o_irq;
  endproperty
  a_alm_clear: assert property (p_alm_clear)
    else $error("alarm access did not clear flag");

  property p_once_sec;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(flag_q) |-> $past(cmp_stb_q) ##0 !cmp_stb_q [*2];
  endproperty
  a_once_sec: assert property (p_once_sec)
    else $error("flag set outside seconds compare");

  property p_tick_cmp;
    @(posedge i_clk) disable iff (i_sys_rst)
      sec_tick |-> s_tick_cmp;
  endproperty
  a_tick_cmp: assert property (p_tick_cmp)
    else $error("compare strobe missing after tick");

  property p_wp_block;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_prot_wr |=> $stable(alarm_q[0]);
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("write accepted under protection");

  property p_wp_self;
    @(posedge i_clk) disable iff (i_sys_rst)
      wr_stb && ev_addr_q == A_CTRL
        |=> ctrl_q[CTRL_WP] == $past(ev_data_q[CTRL_WP]);
  endproperty
  a_wp_self: assert property (p_wp_self)
    else $error("protect bit not writable");

  property p_osc_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      ctrl_q[CTRL_OSC] && !wr_stb |=> $stable(time_q[0]);
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("seconds advanced while disabled");

  property p_zero_bits;
    @(posedge i_clk) disable iff (i_sys_rst)
      ctrl_q[3:1] == 3'h0 && wd_q[7:2] == 6'h00;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("fixed-zero bit set");

  property p_hr24;
    @(posedge i_clk) disable iff (i_sys_rst)
      !time_q[2][HR_12H] && sec_tick && time_q[2][5:0] == 6'h23
        && time_q[1] == SEC_LAST && time_q[0] == SEC_LAST
        && !wr_stb |=> time_q[2] == 8'h00;
  endproperty
  a_hr24: assert property (p_hr24)
    else $error("24-hour rollover wrong");

  property p_osc_stop;
    @(posedge i_clk) disable iff (i_sys_rst)
      ctrl_q[CTRL_OSC] && pin_s2_q[1] |=> !o_osc_run;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator not stopped on battery");

  property p_rsvd_read;
    @(negedge i_sclk) disable iff (frame_rst)
      cmd_q && !rw_q && bit_q == 3'h0 && addr_q > A_CONV
        |=> rd_q == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved address read nonzero");
endmodule : rtcac_top
`default_nettype wire
